/* pkg/lra_monitor_pkg.sv */
// Package for the actuator period and supply monitor register bank.
// Assumes one 250 MHz system clock and an on-chip register access port.
package lra_monitor_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_OL_PERIOD = 8'h20;
    localparam logic [7:0] ADDR_SUPPLY = 8'h21;
    localparam logic [7:0] ADDR_RES_PERIOD = 8'h22;

    // Values after reset
    localparam logic [7:0] RESET_OL_PERIOD = 8'h00;
    localparam logic [7:0] RESET_SUPPLY = 8'h00;
    localparam logic [7:0] RESET_RES_PERIOD = 8'h00;

    // Period code unit: 98.46 us, counted at a 4 ns clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int UNIT_TIME_PS = 98460000;
    localparam logic [14:0] UNIT_CYCLES_DEF = 15'(UNIT_TIME_PS / CLK_PERIOD_PS);
    localparam logic [14:0] HALF_STEP = 15'h0002;

    // Half-units without a back-EMF crossing that count as one failed attempt
    localparam logic [7:0] MISS_HALF_TICKS = 8'hFF;
    // Fewest synchronisation attempts before open-loop fallback
    localparam logic [2:0] FALLBACK_BASE_ATTEMPTS = 3'h3;

    // Drive modes, one-hot
    typedef enum logic [3:0] {
        MODE_IDLE = 4'h1,
        MODE_CLOSED = 4'h2,
        MODE_OPEN = 4'h4,
        MODE_ERM = 4'h8
    } drive_mode_t;

    // One register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Resonance tracker state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [7:0] halfCnt;
        logic [7:0] periodCode;
        logic update;
        logic crossing;
        logic miss;
    } tracker_state_t;

    // Register bank and drive state
    typedef struct packed {
        drive_mode_t mode;
        logic [7:0] openLoopPeriodCode;
        logic [7:0] supplyCode;
        logic [7:0] resonancePeriodCode;
        logic [7:0] rdata;
        logic ack;
        logic [14:0] acc;
        logic halfTick;
        logic [7:0] halfCnt;
        logic polarity;
        logic [2:0] missCnt;
        logic openLoop;
        logic outP;
        logic outN;
    } bank_state_t;

endpackage

/* rtl/resonance_tracker.sv */
// Auto-resonance tracker: times back-EMF zero crossings in half-units.
// Assumes a raw comparator pin and a half-unit tick from the same clock as sys_clk.
`timescale 1ns/100ps
module resonance_tracker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic halfTick,
    input wire logic backEmfComparator,
    output logic [7:0] periodCode,
    output logic update,
    output logic crossing,
    output logic miss
);
    import lra_monitor_pkg::*;

    tracker_state_t s_q;
    tracker_state_t s_d;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.update = 1'b0;
        s_d.crossing = 1'b0;
        s_d.miss = 1'b0;
        // Two-flop synchroniser, third flop for the edge
        s_d.sync1 = backEmfComparator;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        if (!enable) begin
            s_d.halfCnt = 8'h00;
        end else if (s_q.sync2 != s_q.prev) begin
            s_d.periodCode = s_q.halfCnt;
            s_d.update = 1'b1;
            s_d.crossing = 1'b1;
            s_d.halfCnt = 8'h00;
        end else if (halfTick) begin
            if (s_q.halfCnt == MISS_HALF_TICKS) begin
                s_d.miss = 1'b1;
                s_d.halfCnt = 8'h00;
            end else begin
                s_d.halfCnt = s_q.halfCnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign periodCode = s_q.periodCode;
    assign update = s_q.update;
    assign crossing = s_q.crossing;
    assign miss = s_q.miss;
endmodule

/* rtl/resonance_period_code_and_supply_monitor.sv */
// Period and supply monitor register bank with actuator drive polarity.
// Assumes the serial front end, sequencer and supply converter share sys_clk.
`timescale 1ns/100ps
module resonance_period_code_and_supply_monitor #(
    parameter logic [14:0] UNIT_CYCLES = lra_monitor_pkg::UNIT_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire lra_monitor_pkg::reg_req_t regReq,
    input wire logic driveActive,
    input wire logic lraSelect,
    input wire logic openLoopSelect,
    input wire logic ermReverse,
    input wire logic autoFallbackEnable,
    input wire logic [1:0] fallbackAttemptCount,
    input wire logic [7:0] supplySample,
    input wire logic supplySampleValid,
    input wire logic backEmfComparator,
    output logic [7:0] regRdata,
    output logic regAck,
    output logic driveOutP,
    output logic driveOutN,
    output logic openLoopActive
);
    import lra_monitor_pkg::*;

    bank_state_t s_q;
    bank_state_t s_d;
    logic [7:0] trkPeriod;
    logic trkUpdate;
    logic trkCross;
    logic trkMiss;

    // Attempts allowed before fallback for a count code
    function automatic logic [2:0] attemptsFor(input logic [1:0] code);
        attemptsFor = FALLBACK_BASE_ATTEMPTS + {1'b0, code};
    endfunction

    // Read multiplexer, unmapped offsets read zero
    function automatic logic [7:0] readMux(input bank_state_t st, input logic [7:0] addr);
        readMux = 8'h00;
        if (addr == ADDR_OL_PERIOD) begin
            readMux = st.openLoopPeriodCode;
        end else if (addr == ADDR_SUPPLY) begin
            readMux = st.supplyCode;
        end else if (addr == ADDR_RES_PERIOD) begin
            readMux = st.resonancePeriodCode;
        end
    endfunction

    resonance_tracker u_tracker (
        .sys_clk(sys_clk),
        .reset(reset),
        .enable(driveActive & lraSelect),
        .halfTick(s_q.halfTick),
        .backEmfComparator(backEmfComparator),
        .periodCode(trkPeriod),
        .update(trkUpdate),
        .crossing(trkCross),
        .miss(trkMiss)
    );

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.halfTick = 1'b0;

        // Half-unit prescaler: two per unit, exact on average
        if (!driveActive) begin
            s_d.acc = 15'h0000;
        end else if (s_q.acc + HALF_STEP >= UNIT_CYCLES) begin
            s_d.acc = 15'(s_q.acc + HALF_STEP - UNIT_CYCLES);
            s_d.halfTick = 1'b1;
        end else begin
            s_d.acc = 15'(s_q.acc + HALF_STEP);
        end

        // Register writes and reads
        if (regReq.wr) begin
            s_d.ack = 1'b1;
            if (regReq.addr == ADDR_OL_PERIOD) begin
                s_d.openLoopPeriodCode = regReq.wdata;
            end else if (regReq.addr == ADDR_SUPPLY) begin
                s_d.supplyCode = regReq.wdata;
            end else if (regReq.addr == ADDR_RES_PERIOD) begin
                s_d.resonancePeriodCode = regReq.wdata;
            end
        end
        if (regReq.rd) begin
            s_d.ack = 1'b1;
            s_d.rdata = readMux(s_q, regReq.addr);
        end

        if (driveActive && supplySampleValid) begin
            s_d.supplyCode = supplySample;
        end
        if (driveActive && trkUpdate) begin
            s_d.resonancePeriodCode = trkPeriod;
        end

        // Drive mode sequencing
        unique case (s_q.mode)
            MODE_IDLE: begin
                s_d.halfCnt = 8'h00;
                s_d.missCnt = 3'h0;
                s_d.polarity = 1'b0;
                if (driveActive) begin
                    if (!lraSelect) begin
                        s_d.mode = MODE_ERM;
                    end else if (openLoopSelect) begin
                        s_d.mode = MODE_OPEN;
                    end else begin
                        s_d.mode = MODE_CLOSED;
                    end
                end
            end
            MODE_CLOSED: begin
                if (!driveActive) begin
                    s_d.mode = MODE_IDLE;
                end else if (trkCross) begin
                    // Polarity follows each back-EMF crossing
                    s_d.polarity = ~s_q.polarity;
                    s_d.missCnt = 3'h0;
                end else if (trkMiss) begin
                    if (autoFallbackEnable &&
                        (s_q.missCnt + 3'h1 >= attemptsFor(fallbackAttemptCount))) begin
                        s_d.mode = MODE_OPEN;
                        s_d.halfCnt = 8'h00;
                    end else if (s_q.missCnt != 3'h7) begin
                        s_d.missCnt = s_q.missCnt + 3'h1;
                    end
                end
            end
            MODE_OPEN: begin
                if (!driveActive) begin
                    s_d.mode = MODE_IDLE;
                end else if (s_q.halfTick) begin
                    if ({1'b0, s_q.halfCnt} + 9'h001 >= {1'b0, s_q.openLoopPeriodCode}) begin
                        s_d.polarity = ~s_q.polarity;
                        s_d.halfCnt = 8'h00;
                    end else begin
                        s_d.halfCnt = s_q.halfCnt + 8'h01;
                    end
                end
            end
            MODE_ERM: begin
                if (!driveActive) begin
                    s_d.mode = MODE_IDLE;
                end
            end
            default: begin
                s_d.mode = MODE_IDLE;
            end
        endcase

        // Output bridge polarity from the next mode
        s_d.openLoop = (s_d.mode == MODE_OPEN);
        if (s_d.mode == MODE_IDLE) begin
            s_d.outP = 1'b0;
            s_d.outN = 1'b0;
        end else if (s_d.mode == MODE_ERM) begin
            s_d.outP = ~ermReverse;
            s_d.outN = ermReverse;
        end else begin
            s_d.outP = s_d.polarity;
            s_d.outN = ~s_d.polarity;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.mode <= MODE_IDLE;
            s_q.openLoopPeriodCode <= RESET_OL_PERIOD;
            s_q.supplyCode <= RESET_SUPPLY;
            s_q.resonancePeriodCode <= RESET_RES_PERIOD;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign regAck = s_q.ack;
    assign driveOutP = s_q.outP;
    assign driveOutN = s_q.outN;
    assign openLoopActive = s_q.openLoop;
endmodule

/* verification/lra_monitor_assertions.sv */
// Port checker for the period and supply monitor bank.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/100ps
module lra_monitor_assertions #(
    parameter logic [14:0] UNIT_CYCLES = 15'h0014
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire lra_monitor_pkg::reg_req_t regReq,
    input wire logic driveActive,
    input wire logic lraSelect,
    input wire logic openLoopSelect,
    input wire logic ermReverse,
    input wire logic backEmfComparator,
    input wire logic [7:0] regRdata,
    input wire logic regAck,
    input wire logic driveOutP,
    input wire logic driveOutN,
    input wire logic openLoopActive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Register port, bridge and open-loop flag outputs
    ack_follows_req_a: assert property ((regReq.wr || regReq.rd) |=> regAck) else $error("no ack");
    ack_has_cause_a: assert property (regAck |-> $past(regReq.wr || regReq.rd)) else $error("ack");
    rdata_holds_a: assert property ($changed(regRdata) |-> $past(regReq.rd)) else $error("rdata");
    idle_bridge_off_a: assert property (!driveActive |=> !driveOutP && !driveOutN)
        else $error("bridge idle");
    bridge_exclusive_a: assert property (!(driveOutP && driveOutN)) else $error("both on");
    start_polarity_a: assert property ($rose(driveActive) |=> driveOutP != driveOutN)
        else $error("no drive");
    fallback_ends_a: assert property (!driveActive |=> !openLoopActive)
        else $error("open flag");
    motor_reverse_a: assert property ((driveActive && !lraSelect) [*3] ##0 $changed(ermReverse)
        |=> $changed(driveOutP) && driveOutP != driveOutN) else $error("reverse");
    closed_follow_a: assert property ((driveActive && lraSelect && !openLoopSelect
        && !openLoopActive) [*4] ##0 $changed(backEmfComparator) |-> ##[3:4] $changed(driveOutP))
        else $error("closed toggle");
    // Main scenarios
    cov_write: cover property (regReq.wr ##1 regAck);
    cov_open: cover property (driveActive && openLoopActive);
    cov_motor: cover property (driveActive && !lraSelect && ermReverse);
    cov_fallback: cover property (driveActive && lraSelect && !openLoopSelect && openLoopActive);
endmodule
bind resonance_period_code_and_supply_monitor lra_monitor_assertions #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (
    .sys_clk, .reset, .regReq, .driveActive, .lraSelect, .openLoopSelect, .ermReverse,
    .backEmfComparator, .regRdata, .regAck, .driveOutP, .driveOutN, .openLoopActive);

/* verification/lra_host_model.sv */
// Host model issuing single-byte register accesses.
// Assumes an ack exactly one cycle after each strobe.
`timescale 1ns/100ps
module lra_host_model (
    input wire logic sys_clk,
    input wire logic regAck,
    input wire logic [7:0] regRdata,
    output lra_monitor_pkg::reg_req_t regReq
);
    import lra_monitor_pkg::*;
    initial regReq = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    // Strobe one cycle, take the answer with the ack, then scramble the lines
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q,
        output logic k);
        @(negedge sys_clk);
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        q = regRdata;
        k = regAck;
        regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* verification/tb_resonance_period_code_and_supply_monitor.sv */
// Self-checking bench for the period and supply monitor bank.
// Assumes a 4 ns clock and a period unit shortened to 20 cycles.
`timescale 1ns/100ps
module tb_resonance_period_code_and_supply_monitor;
    import lra_monitor_pkg::*;
    logic sys_clk = 0, reset = 1, driveActive = 0, lraSelect = 1, openLoopSelect = 0;
    logic ermReverse = 0, autoFallbackEnable = 0, supplySampleValid = 0, backEmfComparator = 0;
    logic regAck, driveOutP, driveOutN, openLoopActive, k, p;
    logic [1:0] fallbackAttemptCount = 2'h0;
    logic [7:0] supplySample = 8'h00, regRdata, q;
    reg_req_t regReq;
    int mismatches = 0, compares = 0, n;
    resonance_period_code_and_supply_monitor #(.UNIT_CYCLES(15'h0014)) dut_u (.sys_clk(sys_clk),
        .reset(reset), .regReq(regReq), .driveActive(driveActive), .lraSelect(lraSelect),
        .openLoopSelect(openLoopSelect), .ermReverse(ermReverse),
        .autoFallbackEnable(autoFallbackEnable), .fallbackAttemptCount(fallbackAttemptCount),
        .supplySample(supplySample), .supplySampleValid(supplySampleValid),
        .backEmfComparator(backEmfComparator), .regRdata(regRdata), .regAck(regAck),
        .driveOutP(driveOutP), .driveOutN(driveOutN), .openLoopActive(openLoopActive));
    lra_host_model host_u (.sys_clk(sys_clk), .regAck(regAck), .regRdata(regRdata),
        .regReq(regReq));
    // Clock and hang guard
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        #300000;
        mismatches++;
        close_out;
    end
    task automatic check(input logic [7:0] seen, exp, input string m);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task automatic rw(input logic w, input logic [7:0] a, d);
        host_u.access(w, a, d, q, k);
        check({7'h00, k}, 8'h01, "ack");
    endtask
    task automatic gap(output int c);
        p = driveOutP;
        c = 0;
        do begin
            cyc(1);
            c++;
        end while (driveOutP === p && c < 1000);
    endtask
    task automatic emf(input int h, input int t);
        repeat (t) begin
            cyc(h);
            backEmfComparator = ~backEmfComparator;
        end
    endtask
    task automatic t_regs;
        for (int a = 8'h20; a < 8'h24; a++) begin
            rw(0, 8'(a), 8'h00);
            check(q, 8'h00, "reset value");
        end
        rw(1, 8'h23, 8'hA5);
        rw(0, 8'h23, 8'h00);
        check(q, 8'h00, "unmapped");
        for (int a = 8'h20; a < 8'h23; a++) begin
            rw(1, 8'(a), 8'(a + 8'h30));
            rw(0, 8'(a), 8'h00);
            check(q, 8'(a + 8'h30), "read back");
        end
        $display("t_regs done");
    endtask
    task automatic t_supply;
        rw(1, ADDR_SUPPLY, 8'h11);
        for (int i = 0; i < 2; i++) begin
            driveActive = 1'(i);
            supplySample = i ? 8'hB7 : 8'h3C;
            supplySampleValid = 1;
            cyc(1);
            supplySampleValid = 0;
            supplySample = 8'h5A;
            rw(0, ADDR_SUPPLY, 8'h00);
            check(q, i ? 8'hB7 : 8'h11, "supply sample");
        end
        driveActive = 0;
        cyc(2);
        // Idle samples offered, none may land
        supplySample = 8'h5A;
        supplySampleValid = 1;
        cyc(3);
        supplySampleValid = 0;
        rw(0, ADDR_SUPPLY, 8'h00);
        check(q, 8'hB7, "supply held");
        $display("t_supply done");
    endtask
    task automatic t_open;
        rw(1, ADDR_OL_PERIOD, 8'h03);
        openLoopSelect = 1;
        driveActive = 1;
        gap(n);
        gap(n);
        check(8'(n), 8'd30, "open period");
        check({7'h00, openLoopActive}, 8'h01, "open flag");
        driveActive = 0;
        openLoopSelect = 0;
        cyc(3);
        $display("t_open done");
    endtask
    task automatic t_closed;
        driveActive = 1;
        emf(100, 4);
        rw(0, ADDR_RES_PERIOD, 8'h00);
        check(q, 8'd10, "period");
        emf(60, 4);
        rw(0, ADDR_RES_PERIOD, 8'h00);
        check(q, 8'd6, "moved period");
        driveActive = 0;
        emf(90, 3);
        rw(0, ADDR_RES_PERIOD, 8'h00);
        check(q, 8'd6, "period held");
        $display("t_closed done");
    endtask
    task automatic t_erm;
        lraSelect = 0;
        driveActive = 1;
        cyc(4);
        p = driveOutP;
        ermReverse = 1;
        cyc(3);
        check({6'h00, driveOutP, driveOutN}, {6'h00, ~p, p}, "reverse");
        driveActive = 0;
        cyc(2);
        check({6'h00, driveOutP, driveOutN}, 8'h00, "bridge off");
        lraSelect = 1;
        ermReverse = 0;
        $display("t_erm done");
    endtask
    task automatic t_fallback;
        // Misses alone never leave closed loop while fallback is off
        driveActive = 1;
        cyc(4 * 2550);
        check({7'h00, openLoopActive}, 8'h00, "fallback off");
        driveActive = 0;
        cyc(3);
        autoFallbackEnable = 1;
        for (int c = 0; c < 4; c++) begin
            fallbackAttemptCount = 2'(c);
            driveActive = 1;
            cyc((3 + c) * 2550 - 200);
            check({7'h00, openLoopActive}, 8'h00, "early fallback");
            cyc(400);
            check({7'h00, openLoopActive}, 8'h01, "fallback");
            driveActive = 0;
            cyc(3);
        end
        autoFallbackEnable = 0;
        $display("t_fallback done");
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        cyc(12);
        reset = 0;
        cyc(1);
        t_regs;
        t_supply;
        t_open;
        t_closed;
        t_erm;
        t_fallback;
        close_out;
    end
endmodule
